// ---- src/bmc_pkg.sv ----
// Constants shared by the battery monitor control register bank
package bmc_pkg;

   // ****************************************************
   // Register offsets
   // ****************************************************
   localparam logic [7:0] BMC_ADDR_PROT = 8'h00;
   localparam logic [7:0] BMC_ADDR_STAT = 8'h01;
   localparam logic [7:0] BMC_ADDR_NVCTL = 8'h07;
   localparam logic [7:0] BMC_ADDR_SPEC = 8'h08;

   // ****************************************************
   // Field positions
   // ****************************************************
   localparam int BMC_B_HIGH_V = 7;
   localparam int BMC_B_LOW_V = 6;
   localparam int BMC_B_CHG_OC = 5;
   localparam int BMC_B_DIS_OC = 4;
   localparam int BMC_B_CHG_MIR = 3;
   localparam int BMC_B_DIS_MIR = 2;
   localparam int BMC_B_CHG_EN = 1;
   localparam int BMC_B_DIS_EN = 0;
   localparam int BMC_B_SLEEP_EN = 5;
   localparam int BMC_B_OPSEL = 4;
   localparam int BMC_B_HO_EN = 3;
   localparam int BMC_B_ALERT_EN = 2;
   localparam int BMC_B_COPY = 7;
   localparam int BMC_B_LOCK_EN = 6;
   localparam int BMC_B_UPPER_LK = 1;
   localparam int BMC_B_LOWER_LK = 0;
   localparam int BMC_B_PWR_SW = 7;
   localparam int BMC_B_GPIN = 6;
   localparam int BMC_B_HO_SEL = 5;

   // ****************************************************
   // Opcodes, reset values, timing
   // ****************************************************
   localparam logic [7:0] BMC_OP_RDADDR_0 = 8'h33;
   localparam logic [7:0] BMC_OP_RDADDR_1 = 8'h39;
   localparam logic [7:0] BMC_BYTE_ZERO = 8'h00;
   localparam logic [3:0] BMC_STAT_RST = 4'h0;
   localparam logic [7:0] BMC_CRC_POLY = 8'h8c;
   localparam int BMC_IDLE_S = 2;
   localparam int BMC_CLK_HZ = 100_000_000;
   localparam int BMC_IDLE_CYC = BMC_IDLE_S * BMC_CLK_HZ;
   localparam int BMC_IDLE_W = 28;

   // Address check byte, LSB first over the first 56 bits
   function automatic logic [7:0] bmc_crc8(input logic [55:0] d);
      logic [7:0] c;
      logic fb;
      c = 8'h00;
      fb = 1'b0;
      for (int i = 0; i < 56; i++) begin
         fb = c[0] ^ d[i];
         c = {1'b0, c[7:1]};
         if (fb) begin
            c = c ^ BMC_CRC_POLY;
         end
      end
      return c;
   endfunction : bmc_crc8

endpackage : bmc_pkg

// ---- src/bmc_regs.sv ----
// Control and status register bank of the battery monitor
// ****************************************************
// How it works
// - Protection flags set on their condition and stay set until cleared.
// - Charge/discharge enables load from block 1 byte 0 defaults and recall.
// - Switch mirror bits are read-only copies of the control outputs.
// - Charge enable 0 forces charge output high; 1 allows unless protected.
// - Discharge enable 0 forces discharge output high; 1 allows unless protected.
// - Waking from sleep sets both enables to 1.
// - Status bits load from the defaults byte at 31h and on recall.
// - With sleep enable, line low over 2s sleeps, line high wakes.
// - Address read opcode is 33h or 39h by the opcode select bit.
// - Handover command accepted only while handover enable is 1.
// - Alert enable turns the general pin into a threshold alert output.
// - Status bits are read-only, change only via defaults, reset to 0.
// - Copy flag reads 1 during nonvolatile copy; nonvolatile writes blocked.
// - Lock command ignored unless lock enable is 1; cleared after lock.
// - Block lock flags read 1 when that block is locked.
// - Power switch low is latched; only writing 1 clears it.
// - Handover selected sets when handover picks this device, else 0.
// - Fixed 64-bit address: family, 48-bit serial, check byte over 56.
// - Device is always a slave; the host is the only master.
// - General pin bit 0 pulls pin low, 1 releases, read gives level.
// - Sleep or line low over 2s releases pin and forces bit high.
// ****************************************************
`timescale 1ns/1ns
module bmc_regs
   import bmc_pkg::*;
#(
   parameter int IDLE_CYCLES = BMC_IDLE_CYC,
   parameter logic [7:0] FAMILY_CODE = 8'h5a, // Arbitrary value
   parameter logic [47:0] SERIAL_NUM = 48'h0123_4567_89ab // Arbitrary
) (
   input wire logic sys_clk_in, // Device clock
   input wire logic srst_in, // Synchronous reset, high
   input wire logic [7:0] reg_addr_in, // Register address
   input wire logic reg_wr_in, // Write strobe, one cycle
   input wire logic [7:0] reg_wdata_in, // Write data
   output logic [7:0] reg_rdata_out, // Read data, next cycle
   input wire logic high_v_cond_in, // Overvoltage present
   input wire logic low_v_cond_in, // Undervoltage present
   input wire logic chg_oc_cond_in, // Charge overcurrent present
   input wire logic dis_oc_cond_in, // Discharge overcurrent present
   input wire logic [7:0] nv_byte30_in, // Defaults byte at 30h
   input wire logic [7:0] nv_byte31_in, // Defaults byte at 31h
   input wire logic recall_blk1_in, // Block 1 recall pulse
   input wire logic nv_copy_busy_in, // Nonvolatile copy running
   input wire logic nv_wr_req_in, // Nonvolatile write request
   output logic nv_wr_ok_out, // Nonvolatile write allowed
   input wire logic lock_cmd_in, // Lock command pulse
   output logic lock_exec_out, // Lock accepted pulse
   input wire logic upper_lock_in, // Block 1 locked
   input wire logic lower_lock_in, // Block 0 locked
   input wire logic bus_line_in, // Bus line level
   output logic sleep_out, // Sleep mode
   output logic chg_sw_n_out, // Charge control, high = off
   output logic dis_sw_n_out, // Discharge control, high = off
   input wire logic pwr_sw_n_in, // Power switch pin, low active
   input wire logic gpin_in, // General pin level
   output logic gpin_out, // General pin drive value
   output logic gpin_oe_out, // General pin drive enable
   input wire logic alert_cond_in, // Threshold met or exceeded
   output logic [7:0] rdaddr_opcode_out, // Address read opcode
   input wire logic handover_cmd_in, // Handover command seen
   input wire logic handover_match_in, // Handover addressed here
   output logic handover_accept_out, // Handover accepted pulse
   output logic [63:0] net_addr_out // Fixed bus address
);

   // ****************************************************
   // State
   // ****************************************************
   logic [3:0] flags_reg, flags_next;
   logic chg_en_reg, chg_en_next;
   logic dis_en_reg, dis_en_next;
   logic [3:0] stat_reg, stat_next;
   logic lock_en_reg, lock_en_next;
   logic pwr_latch_reg, pwr_latch_next;
   logic gpin_bit_reg, gpin_bit_next;
   logic ho_sel_reg, ho_sel_next;
   logic sleep_reg, sleep_next;
   logic loaded_reg;
   logic idle_reg;
   logic [BMC_IDLE_W-1:0] idle_cnt_reg, idle_cnt_next;
   logic [7:0] rdata_next;
   logic chg_n_reg, dis_n_reg, gout_oe_reg;
   logic nv_ok_reg, lock_x_reg, ho_acc_reg;
   logic [7:0] opc_reg;
   logic [63:0] addr_reg;

   // ****************************************************
   // Decode
   // ****************************************************
   wire wr_prot = reg_wr_in && (reg_addr_in == BMC_ADDR_PROT);
   wire wr_nvctl = reg_wr_in && (reg_addr_in == BMC_ADDR_NVCTL);
   wire wr_spec = reg_wr_in && (reg_addr_in == BMC_ADDR_SPEC);
   wire [3:0] conds = {high_v_cond_in, low_v_cond_in,
                       chg_oc_cond_in, dis_oc_cond_in};
   wire [3:0] keep = wr_prot ? reg_wdata_in[BMC_B_HIGH_V:BMC_B_DIS_OC]
                             : 4'hf;
   wire sleep_en = stat_reg[BMC_B_SLEEP_EN-BMC_B_ALERT_EN];
   wire opsel = stat_reg[BMC_B_OPSEL-BMC_B_ALERT_EN];
   wire ho_en = stat_reg[BMC_B_HO_EN-BMC_B_ALERT_EN];
   wire alert_en = stat_reg[0];
   wire wake = sleep_reg && (bus_line_in || !pwr_sw_n_in);
   wire go_sleep = !sleep_reg && sleep_en && idle_reg;
   wire recall = recall_blk1_in || !loaded_reg;
   wire pin_off = sleep_reg || idle_reg;
   wire chg_block = !chg_en_reg || high_v_cond_in || chg_oc_cond_in
                    || sleep_reg;
   wire dis_block = !dis_en_reg || low_v_cond_in || dis_oc_cond_in
                    || sleep_reg;
   wire ho_ok = handover_cmd_in && ho_en;

   // Sticky flags, set beats the host clear
   assign flags_next = (flags_reg & keep) | conds;

   // Enables: wake over recall over host write
   assign chg_en_next = wake ? 1'b1
      : recall ? nv_byte30_in[BMC_B_CHG_EN]
      : wr_prot ? reg_wdata_in[BMC_B_CHG_EN] : chg_en_reg;
   assign dis_en_next = wake ? 1'b1
      : recall ? nv_byte30_in[BMC_B_DIS_EN]
      : wr_prot ? reg_wdata_in[BMC_B_DIS_EN] : dis_en_reg;

   // Status bits change only from the defaults byte
   assign stat_next = recall
      ? nv_byte31_in[BMC_B_SLEEP_EN:BMC_B_ALERT_EN] : stat_reg;

   // Lock enable, cleared once a lock runs
   assign lock_en_next = (lock_cmd_in && lock_en_reg) ? 1'b0
      : wr_nvctl ? reg_wdata_in[BMC_B_LOCK_EN] : lock_en_reg;

   // Power switch latch: low reads 0 until a 1 is written
   assign pwr_latch_next = !pwr_sw_n_in ? 1'b0
      : (wr_spec && reg_wdata_in[BMC_B_PWR_SW]) ? 1'b1 : pwr_latch_reg;

   // General pin control bit, forced high while the pin is off
   assign gpin_bit_next = pin_off ? 1'b1
      : wr_spec ? reg_wdata_in[BMC_B_GPIN] : gpin_bit_reg;

   // Handover selection follows the last accepted handover
   assign ho_sel_next = ho_ok ? handover_match_in : ho_sel_reg;

   // Sleep entry and exit
   assign sleep_next = go_sleep ? 1'b1
      : wake ? 1'b0 : sleep_reg;

   // Count how long the bus line has been low
   assign idle_cnt_next = bus_line_in ? '0
      : (idle_cnt_reg == BMC_IDLE_W'(IDLE_CYCLES)) ? idle_cnt_reg
      : idle_cnt_reg + 1'b1;

   // Read mux, reserved bits as zero
   assign rdata_next =
      (reg_addr_in == BMC_ADDR_PROT) ? {flags_reg, chg_n_reg, dis_n_reg,
                                        chg_en_reg, dis_en_reg}
      : (reg_addr_in == BMC_ADDR_STAT) ? {2'b00, stat_reg, 2'b00}
      : (reg_addr_in == BMC_ADDR_NVCTL) ? {nv_copy_busy_in, lock_en_reg,
                                 4'h0, upper_lock_in, lower_lock_in}
      : (reg_addr_in == BMC_ADDR_SPEC) ? {pwr_latch_reg,
                                 gpin_in || pin_off, ho_sel_reg, 5'h00}
      : BMC_BYTE_ZERO;

   // ****************************************************
   // Register update
   // ****************************************************
   // Sticky protection flags
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         flags_reg <= 4'h0;
      end else begin
         flags_reg <= flags_next;
      end
   end

   // Charge and discharge enables
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         chg_en_reg <= 1'b0;
         dis_en_reg <= 1'b0;
      end else begin
         chg_en_reg <= chg_en_next;
         dis_en_reg <= dis_en_next;
      end
   end

   // Status configuration bits
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         stat_reg <= BMC_STAT_RST;
      end else begin
         stat_reg <= stat_next;
      end
   end

   // Lock enable bit
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         lock_en_reg <= 1'b0;
      end else begin
         lock_en_reg <= lock_en_next;
      end
   end

   // Power switch latch, no low seen after reset
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         pwr_latch_reg <= 1'b1;
      end else begin
         pwr_latch_reg <= pwr_latch_next;
      end
   end

   // General pin control bit, released after reset
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         gpin_bit_reg <= 1'b1;
      end else begin
         gpin_bit_reg <= gpin_bit_next;
      end
   end

   // Handover selected bit
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         ho_sel_reg <= 1'b0;
      end else begin
         ho_sel_reg <= ho_sel_next;
      end
   end

   // Sleep mode and first load of the defaults
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         sleep_reg <= 1'b0;
         loaded_reg <= 1'b0;
      end else begin
         sleep_reg <= sleep_next;
         loaded_reg <= 1'b1;
      end
   end

   // Idle timer, flags more than the set time of low line
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         idle_cnt_reg <= '0;
         idle_reg <= 1'b0;
      end else begin
         idle_cnt_reg <= idle_cnt_next;
         idle_reg <= !bus_line_in
                     && (idle_cnt_reg == BMC_IDLE_W'(IDLE_CYCLES));
      end
   end

   // ****************************************************
   // Registered outputs
   // ****************************************************
   // Switch drives, pin drive and read data
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         chg_n_reg <= 1'b1;
         dis_n_reg <= 1'b1;
         gout_oe_reg <= 1'b0;
         reg_rdata_out <= BMC_BYTE_ZERO;
      end else begin
         chg_n_reg <= chg_block;
         dis_n_reg <= dis_block;
         gout_oe_reg <= !pin_off && (alert_en ? alert_cond_in
                                              : !gpin_bit_reg);
         reg_rdata_out <= rdata_next;
      end
   end

   // Command answers, opcode and bus address
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         nv_ok_reg <= 1'b0;
         lock_x_reg <= 1'b0;
         ho_acc_reg <= 1'b0;
         opc_reg <= BMC_OP_RDADDR_0;
         addr_reg <= '0;
      end else begin
         nv_ok_reg <= nv_wr_req_in && !nv_copy_busy_in;
         lock_x_reg <= lock_cmd_in && lock_en_reg;
         ho_acc_reg <= ho_ok;
         opc_reg <= opsel ? BMC_OP_RDADDR_1 : BMC_OP_RDADDR_0;
         addr_reg <= {bmc_crc8({SERIAL_NUM, FAMILY_CODE}),
                      SERIAL_NUM, FAMILY_CODE};
      end
   end

   // Slave only: the pin drive is always low when enabled
   assign chg_sw_n_out = chg_n_reg;
   assign dis_sw_n_out = dis_n_reg;
   assign gpin_out = 1'b0;
   assign gpin_oe_out = gout_oe_reg;
   assign nv_wr_ok_out = nv_ok_reg;
   assign lock_exec_out = lock_x_reg;
   assign handover_accept_out = ho_acc_reg;
   assign rdaddr_opcode_out = opc_reg;
   assign net_addr_out = addr_reg;
   assign sleep_out = sleep_reg;

endmodule : bmc_regs

// ---- test/bmc_host_model.sv ----
// Host side model: bus line and general pin pull-ups
`timescale 1ns/1ns
module bmc_host_model (
   input wire logic gpin_oe_in, // Device pulls pin low
   input wire logic hold_low_in, // Host keeps bus line low
   output logic bus_line_out, // Bus line level
   output logic gpin_level_out // Resolved pin level
);
   // Only the host pulls the bus line; both lines idle high
   assign bus_line_out = !hold_low_in;
   assign gpin_level_out = !gpin_oe_in;
endmodule : bmc_host_model

// ---- test/bmc_regs_checker.sv ----
// Assertion checker bound to the battery monitor register bank
`timescale 1ns/1ns
module bmc_regs_checker
   import bmc_pkg::*;
(
   input wire logic sys_clk_in, // Clock
   input wire logic srst_in, // Reset
   input wire logic [7:0] reg_addr_in, // Address
   input wire logic reg_wr_in, // Write strobe
   input wire logic [7:0] reg_wdata_in, // Write data
   input wire logic [7:0] reg_rdata_out, // Read data
   input wire logic low_v_cond_in, // Undervoltage
   input wire logic dis_oc_cond_in, // Discharge overcurrent
   input wire logic nv_copy_busy_in, // Copy running
   input wire logic nv_wr_req_in, // Write request
   input wire logic nv_wr_ok_out, // Write allowed
   input wire logic lock_cmd_in, // Lock command
   input wire logic lock_exec_out, // Lock accepted
   input wire logic handover_cmd_in, // Handover command
   input wire logic handover_accept_out, // Handover accepted
   input wire logic sleep_out, // Sleep
   input wire logic gpin_oe_out, // Pin drive
   input wire logic chg_sw_n_out, // Charge off
   input wire logic dis_sw_n_out // Discharge off
);
   // ****************************************************
   // Properties
   // ****************************************************
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (srst_in);
   property p_chg_off;
      reg_wr_in && reg_addr_in == BMC_ADDR_PROT && !reg_wdata_in[BMC_B_CHG_EN]
         |=> ##1 (chg_sw_n_out || $past(sleep_out, 2));
   endproperty
   a_chg_off: assert property (p_chg_off) else $error("charge on");
   property p_dis_ovr;
      low_v_cond_in || dis_oc_cond_in |=> dis_sw_n_out;
   endproperty
   a_dis_ovr: assert property (p_dis_ovr) else $error("discharge on");
   property p_mirror;
      !$past(srst_in) && $past(reg_addr_in) == BMC_ADDR_PROT |->
         reg_rdata_out[3] == $past(chg_sw_n_out) &&
         reg_rdata_out[2] == $past(dis_sw_n_out);
   endproperty
   a_mirror: assert property (p_mirror) else $error("bad mirror");
   property p_resv;
      !$past(srst_in) && $past(reg_addr_in) == BMC_ADDR_STAT |->
         reg_rdata_out[7:6] == 2'b00 && reg_rdata_out[1:0] == 2'b00;
   endproperty
   a_resv: assert property (p_resv) else $error("reserved set");
   property p_copy;
      !$past(srst_in) |->
         nv_wr_ok_out == $past(nv_wr_req_in && !nv_copy_busy_in);
   endproperty
   a_copy: assert property (p_copy) else $error("bad write ok");
   property p_lock;
      lock_exec_out && lock_cmd_in && !$past(reg_wr_in) |=> !lock_exec_out;
   endproperty
   a_lock: assert property (p_lock) else $error("lock twice");
   property p_ho;
      handover_accept_out |-> $past(handover_cmd_in);
   endproperty
   a_ho: assert property (p_ho) else $error("stray handover");
   property p_pin_off;
      sleep_out && $past(sleep_out) |-> !gpin_oe_out;
   endproperty
   a_pin_off: assert property (p_pin_off) else $error("pin driven");
   c_lock: cover property (lock_exec_out);
   c_ho: cover property (handover_accept_out);
   c_sleep: cover property ($rose(sleep_out));
endmodule : bmc_regs_checker

bind bmc_regs bmc_regs_checker u_chk (.*);

// ---- test/bmc_regs_tb.sv ----
// Self-checking testbench of the battery monitor register bank
`timescale 1ns/1ns
module bmc_regs_tb
   import bmc_pkg::*;
;
   localparam logic [7:0] FAM = 8'ha5; // Arbitrary value
   localparam logic [47:0] SER = 48'h1122_3344_5566; // Arbitrary value
   logic clk, rst = 1'b1, wr = 1'b0, busy = 1'b0, nvreq = 1'b0, ul = 1'b0;
   logic ll = 1'b0, hold = 1'b0, psn = 1'b1, alert = 1'b0, hom = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, b30 = 8'h03, b31 = 8'h00;
   logic [3:0] cond = 4'h0;
   logic [2:0] pls = 3'h0;
   logic nvok, lexec, sleep, chg, dis, gpl, oe, hoa, bus, gpo;
   logic [7:0] rdata, opc;
   logic [63:0] naddr;
   int bad_count = 0, total_checks = 0;
   // ****************************************************
   // Design and host model
   // ****************************************************
   bmc_regs #(.IDLE_CYCLES(20), .FAMILY_CODE(FAM), .SERIAL_NUM(SER)) dut (
      .sys_clk_in(clk), .srst_in(rst), .reg_addr_in(addr), .reg_wr_in(wr),
      .reg_wdata_in(wdata), .reg_rdata_out(rdata), .high_v_cond_in(cond[3]),
      .low_v_cond_in(cond[2]), .chg_oc_cond_in(cond[1]),
      .dis_oc_cond_in(cond[0]), .nv_byte30_in(b30), .nv_byte31_in(b31),
      .recall_blk1_in(pls[0]), .nv_copy_busy_in(busy), .nv_wr_req_in(nvreq),
      .nv_wr_ok_out(nvok), .lock_cmd_in(pls[1]), .lock_exec_out(lexec),
      .upper_lock_in(ul), .lower_lock_in(ll), .bus_line_in(bus),
      .sleep_out(sleep), .chg_sw_n_out(chg), .dis_sw_n_out(dis),
      .pwr_sw_n_in(psn), .gpin_in(gpl), .gpin_out(gpo), .gpin_oe_out(oe),
      .alert_cond_in(alert), .rdaddr_opcode_out(opc),
      .handover_cmd_in(pls[2]), .handover_match_in(hom),
      .handover_accept_out(hoa), .net_addr_out(naddr));
   bmc_host_model host (.gpin_oe_in(oe), .hold_low_in(hold),
      .bus_line_out(bus), .gpin_level_out(gpl));
   // ****************************************************
   // Tasks
   // ****************************************************
   task automatic end_sim();
      if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_sim
   task automatic chkv(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chkv
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      tick(1);
      addr = a;
      wdata = d;
      wr = 1'b1;
      tick(1);
      wr = 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      tick(1);
      addr = a;
      tick(1);
      chkv({56'h0, rdata}, {56'h0, e});
   endtask : rd_reg
   task automatic pulse(input int i);
      tick(1);
      pls[i] = 1'b1;
      tick(1);
      pls = 3'h0;
   endtask : pulse
   // Reference check byte, LSB first
   function automatic logic [7:0] ref_crc(input logic [55:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < 56; i++) begin
         c = (c[0] ^ d[i]) ? ({1'b0, c[7:1]} ^ 8'h8c) : {1'b0, c[7:1]};
      end
      return c;
   endfunction : ref_crc
   // ****************************************************
   // Clock, watchdog and test sequence
   // ****************************************************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (3000) @(posedge clk);
      bad_count++;
      end_sim();
   end
   initial begin
      tick(6);
      rst = 1'b0;
      tick(2);
      rd_reg(BMC_ADDR_PROT, 8'h03);
      rd_reg(8'h05, 8'h00);
      chkv(naddr, {ref_crc({SER, FAM}), SER, FAM});
      cond = 4'hf;
      tick(1);
      cond = 4'h0;
      rd_reg(BMC_ADDR_PROT, 8'hf3);
      wr_reg(BMC_ADDR_PROT, 8'h03);
      rd_reg(BMC_ADDR_PROT, 8'h03);
      cond = 4'h8;
      wr_reg(BMC_ADDR_PROT, 8'h03);
      rd_reg(BMC_ADDR_PROT, 8'h8b);
      cond = 4'h0;
      wr_reg(BMC_ADDR_PROT, 8'h0c);
      rd_reg(BMC_ADDR_PROT, 8'h0c);
      wr_reg(BMC_ADDR_PROT, 8'h02);
      rd_reg(BMC_ADDR_PROT, 8'h06);
      chkv({63'h0, chg}, 64'h0);
      chkv({63'h0, dis}, 64'h1);
      b31 = 8'hff;
      pulse(0);
      wr_reg(BMC_ADDR_STAT, 8'h00);
      rd_reg(BMC_ADDR_STAT, 8'h3c);
      chkv({56'h0, opc}, 64'h39);
      alert = 1'b1;
      tick(2);
      chkv({63'h0, oe}, 64'h1);
      alert = 1'b0;
      hom = 1'b1;
      pulse(2);
      chkv({63'h0, hoa}, 64'h1);
      hold = 1'b1;
      tick(25);
      chkv({62'h0, sleep, oe}, 64'h2);
      rd_reg(BMC_ADDR_SPEC, 8'he0);
      wr_reg(BMC_ADDR_PROT, 8'h00);
      tick(3);
      hold = 1'b0;
      tick(1);
      rd_reg(BMC_ADDR_PROT, 8'h03);
      b31 = 8'h00;
      pulse(0);
      rd_reg(BMC_ADDR_STAT, 8'h00);
      pulse(2);
      chkv({55'h0, hoa, opc}, 64'h33);
      wr_reg(BMC_ADDR_SPEC, 8'h80);
      rd_reg(BMC_ADDR_SPEC, 8'ha0);
      chkv({63'h0, gpo}, 64'h0);
      psn = 1'b0;
      wr_reg(BMC_ADDR_SPEC, 8'hc0);
      psn = 1'b1;
      rd_reg(BMC_ADDR_SPEC, 8'h60);
      wr_reg(BMC_ADDR_SPEC, 8'hc0);
      rd_reg(BMC_ADDR_SPEC, 8'he0);
      pulse(1);
      chkv({63'h0, lexec}, 64'h0);
      wr_reg(BMC_ADDR_NVCTL, 8'h40);
      rd_reg(BMC_ADDR_NVCTL, 8'h40);
      pls[1] = 1'b1;
      tick(1);
      chkv({63'h0, lexec}, 64'h1);
      tick(1);
      pls = 3'h0;
      chkv({63'h0, lexec}, 64'h0);
      {ul, ll, busy, nvreq} = 4'hf;
      rd_reg(BMC_ADDR_NVCTL, 8'h83);
      chkv({63'h0, nvok}, 64'h0);
      busy = 1'b0;
      tick(2);
      chkv({63'h0, nvok}, 64'h1);
      end_sim();
   end
endmodule : bmc_regs_tb
